// *** rtl/irf_flags.sv ***
// How it works
// - Timer-A flag sets when the timer-A count goes from ff to 00.
// - Accepting an interrupt leaves all request flags as they are.
// - A flag clears only when software writes 0; writing 1 keeps it.
// - First request register bits 6..3 read 1 and ignore writes.
// - Event pin flag sets on selected edge when pin is in interrupt use.
// - Edge pin n flag sets on its selected edge when pin n is enabled.
// - Direct-transfer flag sets on a direct transfer with enable bit at 1.
// - Converter flag sets when conversion ends and busy bit falls to 0.
// - Timer-F-high flag: high match in 8-bit mode, full match in 16-bit.
// - Timer-F-low flag sets on low match only in 8-bit mode.
// - Counter flag: upper overflow in 16-bit, either overflow in 8-bit mode.
// - Second request register bits 5, 4, 1 read 1 and ignore writes.
// - Wakeup pin n flag sets on its edge when pin is in wakeup use.
// - Wakeup edge bit n: 0 selects falling, 1 selects rising edge.
// - Reset clears the wakeup edge select register to 00.
// - Eleven external sources: eight wakeup, two edge pins, one event pin.
// - Event pin edge choice is falling, rising or both, by two bits.
// - A set flag is requested only while its enable bit is 1.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module irf_flags (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire irf_pkg::irf_pins_t pins,
    input wire irf_pkg::irf_events_t events,
    output irf_pkg::irf_requests_t requests,
    output logic [7:0] request_flags_one,
    output logic [7:0] request_flags_two,
    output logic [7:0] wakeup_request_flags
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Edge test on synchronised samples, rise=1 rising, rise=0 falling
    function automatic logic edge_hit(input logic prev, input logic cur, input logic rise);
        edge_hit = rise ? (!prev && cur) : (prev && !cur);
    endfunction

    // Address decode shared by error response and write strobes
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == irf_pkg::ADDR_REQ_ONE) || (addr == irf_pkg::ADDR_REQ_TWO) ||
                    (addr == irf_pkg::ADDR_WAKE_REQ) || (addr == irf_pkg::ADDR_WAKE_EDGE) ||
                    (addr == irf_pkg::ADDR_ENABLE_ONE) || (addr == irf_pkg::ADDR_ENABLE_TWO) ||
                    (addr == irf_pkg::ADDR_PIN_CONFIG) || (addr == irf_pkg::ADDR_WAKE_MODE);
    endfunction

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] wakeup_edge_select;
    logic [7:0] enable_one;
    logic [7:0] enable_two;
    logic [7:0] pin_config;
    logic [7:0] wakeup_pin_mode;
    logic [irf_pkg::SYNC_WIDTH-1:0] sync_first;
    logic [irf_pkg::SYNC_WIDTH-1:0] sync_second;
    logic [irf_pkg::SYNC_WIDTH-1:0] sync_prev;
    logic [7:0] timer_a_prev;
    logic busy_prev;
    logic wr_access;
    logic setup_phase;
    logic [7:0] clear_keep;
    logic [7:0] set_one;
    logic [7:0] set_two;
    logic [7:0] set_wake;
    logic [7:0] next_rdata;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------

    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !is_mapped(paddr);
    assign wr_access = psel && penable && pwrite && is_mapped(paddr);
    assign setup_phase = psel && !penable;
    assign clear_keep = pwdata[7:0];

    // Read mux; fixed bits are ORed in so they always read as 1
    always_comb begin
        next_rdata = irf_pkg::RESET_BYTE;
        if (paddr == irf_pkg::ADDR_REQ_ONE) begin
            next_rdata = request_flags_one | irf_pkg::REQ_ONE_FIXED;
        end else if (paddr == irf_pkg::ADDR_REQ_TWO) begin
            next_rdata = request_flags_two | irf_pkg::REQ_TWO_FIXED;
        end else if (paddr == irf_pkg::ADDR_WAKE_REQ) begin
            next_rdata = wakeup_request_flags;
        end else if (paddr == irf_pkg::ADDR_WAKE_EDGE) begin
            next_rdata = wakeup_edge_select;
        end else if (paddr == irf_pkg::ADDR_ENABLE_ONE) begin
            next_rdata = enable_one | irf_pkg::ENABLE_ONE_FIXED;
        end else if (paddr == irf_pkg::ADDR_ENABLE_TWO) begin
            next_rdata = enable_two | irf_pkg::ENABLE_TWO_FIXED;
        end else if (paddr == irf_pkg::ADDR_PIN_CONFIG) begin
            next_rdata = pin_config;
        end else if (paddr == irf_pkg::ADDR_WAKE_MODE) begin
            next_rdata = wakeup_pin_mode;
        end
    end

    // Read data captured in the setup cycle so it leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase) begin
            prdata <= {24'h00_0000, next_rdata};
        end
    end

    // ------------------------------------------------------------
    // Plain read/write control registers
    // ------------------------------------------------------------

    // Wakeup edge select, cleared by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wakeup_edge_select <= irf_pkg::RESET_BYTE;
        end else if (wr_access && paddr == irf_pkg::ADDR_WAKE_EDGE) begin
            wakeup_edge_select <= pwdata[7:0];
        end
    end

    // Enable registers; only the defined bits are stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_one <= irf_pkg::RESET_BYTE;
            enable_two <= irf_pkg::RESET_BYTE;
        end else if (wr_access) begin
            if (paddr == irf_pkg::ADDR_ENABLE_ONE) begin
                enable_one <= pwdata[7:0] & irf_pkg::ENABLE_ONE_BITS;
            end
            if (paddr == irf_pkg::ADDR_ENABLE_TWO) begin
                enable_two <= pwdata[7:0] & irf_pkg::ENABLE_TWO_BITS;
            end
        end
    end

    // Pin function and edge choices for the edge and event pins, and wakeup pin use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_config <= irf_pkg::RESET_BYTE;
            wakeup_pin_mode <= irf_pkg::RESET_BYTE;
        end else if (wr_access) begin
            if (paddr == irf_pkg::ADDR_PIN_CONFIG) begin
                pin_config <= pwdata[7:0] & irf_pkg::PIN_CONFIG_BITS;
            end
            if (paddr == irf_pkg::ADDR_WAKE_MODE) begin
                wakeup_pin_mode <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers and edge history
    // ------------------------------------------------------------

    // Two flops, then a third stage kept only as edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_first <= '0;
            sync_second <= '0;
            sync_prev <= '0;
        end else begin
            sync_first <= pins;
            sync_second <= sync_first;
            sync_prev <= sync_second;
        end
    end

    // History of peripheral levels for wrap and completion detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_a_prev <= irf_pkg::COUNT_ZERO;
            busy_prev <= 1'b0;
        end else begin
            timer_a_prev <= events.timer_a_count;
            busy_prev <= events.converter_start_busy_bit;
        end
    end

    // ------------------------------------------------------------
    // Set conditions
    // ------------------------------------------------------------

    // Pin edges: bits 10..3 wakeup, 2..1 edge pins, 0 event pin
    always_comb begin
        set_one = irf_pkg::RESET_BYTE;
        set_two = irf_pkg::RESET_BYTE;
        set_wake = irf_pkg::RESET_BYTE;
        set_one[irf_pkg::TIMER_A_BIT] = (timer_a_prev == irf_pkg::COUNT_MAX) &&
                                        (events.timer_a_count == irf_pkg::COUNT_ZERO);
        // Event pin: 00 falling, 01 rising, 1x both edges
        if (pin_config[irf_pkg::CFG_EVENT_ENABLE_BIT]) begin
            if (pin_config[irf_pkg::CFG_EVENT_SEL_LSB+1]) begin
                set_one[irf_pkg::EVENT_PIN_BIT] = sync_prev[0] != sync_second[0];
            end else begin
                set_one[irf_pkg::EVENT_PIN_BIT] = edge_hit(sync_prev[0], sync_second[0],
                                                           pin_config[irf_pkg::CFG_EVENT_SEL_LSB]);
            end
        end
        for (int n = 0; n < 2; n++) begin
            set_one[n] = pin_config[irf_pkg::CFG_EDGE_ENABLE_LSB+n] &&
                         edge_hit(sync_prev[n+1], sync_second[n+1], pin_config[n]);
        end
        for (int n = 0; n < 8; n++) begin
            set_wake[n] = wakeup_pin_mode[n] &&
                          edge_hit(sync_prev[n+3], sync_second[n+3], wakeup_edge_select[n]);
        end
        set_two[irf_pkg::DIRECT_BIT] = events.direct_transfer_done && events.direct_transfer_enable;
        set_two[irf_pkg::CONVERTER_BIT] = busy_prev && !events.converter_start_busy_bit;
        set_two[irf_pkg::TF_HIGH_BIT] = events.timer_f_mode_16 ? events.timer_f_full_match
                                                               : events.timer_f_high_match;
        set_two[irf_pkg::TF_LOW_BIT] = !events.timer_f_mode_16 && events.timer_f_low_match;
        set_two[irf_pkg::EVENT_CTR_BIT] = events.event_counter_upper_ovf ||
                                          (!events.event_counter_mode_16 &&
                                           events.event_counter_lower_ovf);
    end

    // ------------------------------------------------------------
    // Request flag registers
    // ------------------------------------------------------------

    // Written 0 clears, written 1 keeps, set wins over clear.
    // Interrupt acceptance is deliberately not an input to these flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            request_flags_one <= irf_pkg::RESET_BYTE;
        end else if (wr_access && paddr == irf_pkg::ADDR_REQ_ONE) begin
            request_flags_one <= ((request_flags_one & clear_keep) | set_one) & irf_pkg::REQ_ONE_FLAGS;
        end else begin
            request_flags_one <= (request_flags_one | set_one) & irf_pkg::REQ_ONE_FLAGS;
        end
    end

    // Same scheme; fixed bits never stored so writes cannot move them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            request_flags_two <= irf_pkg::RESET_BYTE;
        end else if (wr_access && paddr == irf_pkg::ADDR_REQ_TWO) begin
            request_flags_two <= ((request_flags_two & clear_keep) | set_two) & irf_pkg::REQ_TWO_FLAGS;
        end else begin
            request_flags_two <= (request_flags_two | set_two) & irf_pkg::REQ_TWO_FLAGS;
        end
    end

    // Wakeup flags, all eight bits are flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wakeup_request_flags <= irf_pkg::RESET_BYTE;
        end else if (wr_access && paddr == irf_pkg::ADDR_WAKE_REQ) begin
            wakeup_request_flags <= (wakeup_request_flags & clear_keep) | set_wake;
        end else begin
            wakeup_request_flags <= wakeup_request_flags | set_wake;
        end
    end

    // ------------------------------------------------------------
    // Requests to the interrupt controller
    // ------------------------------------------------------------

    // Registered, so a request lags its flag by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            requests <= '0;
        end else begin
            requests.timer_a <= request_flags_one[irf_pkg::TIMER_A_BIT] &&
                                enable_one[irf_pkg::TIMER_A_BIT];
            requests.wakeup <= (|wakeup_request_flags) && enable_one[irf_pkg::WAKE_ENABLE_BIT];
            requests.event_pin <= request_flags_one[irf_pkg::EVENT_PIN_BIT] &&
                                  enable_one[irf_pkg::EVENT_PIN_BIT];
            requests.edge_pin <= request_flags_one[1:0] & enable_one[1:0];
            requests.direct_transfer <= request_flags_two[irf_pkg::DIRECT_BIT] &&
                                        enable_two[irf_pkg::DIRECT_BIT];
            requests.converter <= request_flags_two[irf_pkg::CONVERTER_BIT] &&
                                  enable_two[irf_pkg::CONVERTER_BIT];
            requests.timer_f_high <= request_flags_two[irf_pkg::TF_HIGH_BIT] &&
                                     enable_two[irf_pkg::TF_HIGH_BIT];
            requests.timer_f_low <= request_flags_two[irf_pkg::TF_LOW_BIT] &&
                                    enable_two[irf_pkg::TF_LOW_BIT];
            requests.event_counter <= request_flags_two[irf_pkg::EVENT_CTR_BIT] &&
                                      enable_two[irf_pkg::EVENT_CTR_BIT];
        end
    end

endmodule

`default_nettype wire

// *** rtl/irf_pkg.sv ***
package irf_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_REQ_ONE = 8'h00;
    localparam logic [7:0] ADDR_REQ_TWO = 8'h04;
    localparam logic [7:0] ADDR_WAKE_REQ = 8'h08;
    localparam logic [7:0] ADDR_WAKE_EDGE = 8'h0c;
    localparam logic [7:0] ADDR_ENABLE_ONE = 8'h10;
    localparam logic [7:0] ADDR_ENABLE_TWO = 8'h14;
    localparam logic [7:0] ADDR_PIN_CONFIG = 8'h18;
    localparam logic [7:0] ADDR_WAKE_MODE = 8'h1c;

    // ------------------------------------------------------------
    // Field layout and fixed bits
    // ------------------------------------------------------------
    localparam logic [7:0] REQ_ONE_FLAGS = 8'h87;
    localparam logic [7:0] REQ_ONE_FIXED = 8'h78;
    localparam logic [7:0] REQ_TWO_FLAGS = 8'hcd;
    localparam logic [7:0] REQ_TWO_FIXED = 8'h32;
    localparam logic [7:0] ENABLE_ONE_BITS = 8'ha7;
    localparam logic [7:0] ENABLE_ONE_FIXED = 8'h58;
    localparam logic [7:0] ENABLE_TWO_BITS = 8'hcd;
    localparam logic [7:0] ENABLE_TWO_FIXED = 8'h32;
    localparam logic [7:0] PIN_CONFIG_BITS = 8'h7f;
    localparam int TIMER_A_BIT = 7;
    localparam int EVENT_PIN_BIT = 2;
    localparam int WAKE_ENABLE_BIT = 5;
    localparam int DIRECT_BIT = 7;
    localparam int CONVERTER_BIT = 6;
    localparam int TF_HIGH_BIT = 3;
    localparam int TF_LOW_BIT = 2;
    localparam int EVENT_CTR_BIT = 0;
    localparam int CFG_EVENT_SEL_LSB = 2;
    localparam int CFG_EVENT_ENABLE_BIT = 4;
    localparam int CFG_EDGE_ENABLE_LSB = 5;

    // ------------------------------------------------------------
    // Reset values and constants
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam int SYNC_WIDTH = 11;

    typedef struct packed {
        logic [7:0] wakeup_pin;
        logic [1:0] edge_request_pin;
        logic event_counter_pin;
    } irf_pins_t;

    typedef struct packed {
        logic [7:0] timer_a_count;
        logic direct_transfer_done;
        logic direct_transfer_enable;
        logic converter_start_busy_bit;
        logic timer_f_mode_16;
        logic timer_f_high_match;
        logic timer_f_low_match;
        logic timer_f_full_match;
        logic event_counter_mode_16;
        logic event_counter_upper_ovf;
        logic event_counter_lower_ovf;
        logic interrupt_accept;
    } irf_events_t;

    typedef struct packed {
        logic timer_a;
        logic wakeup;
        logic event_pin;
        logic [1:0] edge_pin;
        logic direct_transfer;
        logic converter;
        logic timer_f_high;
        logic timer_f_low;
        logic event_counter;
    } irf_requests_t;

endpackage

// *** tb/irf_flags_properties.sv ***
`timescale 1ns/100ps
`default_nettype none

module irf_flags_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire irf_pkg::irf_pins_t pins,
    input wire irf_pkg::irf_events_t events,
    input wire irf_pkg::irf_requests_t requests,
    input wire logic [7:0] request_flags_one,
    input wire logic [7:0] request_flags_two,
    input wire logic [7:0] wakeup_request_flags
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_two;
    logic rd_acc;
    logic [7:0] keep_two;
    // Flags that no write-0 targets this cycle must survive the edge
    assign wr_two = psel && penable && pwrite && (paddr == irf_pkg::ADDR_REQ_TWO);
    assign rd_acc = psel && penable && !pwrite;
    assign keep_two = request_flags_two & ~(wr_two ? ~pwdata[7:0] : 8'h00);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_timer_a_wrap: assert property ((events.timer_a_count == 8'h00 && $past(events.timer_a_count) == 8'hff)
        |=> request_flags_one[7]) else $error("timer A wrap did not set its flag");
    a_flags_sticky: assert property (|keep_two |=> (request_flags_two & $past(keep_two)) == $past(keep_two))
        else $error("flag lost without a write of 0");
    a_fixed_one_read: assert property (rd_acc && paddr == irf_pkg::ADDR_REQ_ONE |-> prdata[6:3] == 4'hf)
        else $error("fixed bits of first flag register not read as 1");
    a_fixed_two_read: assert property (rd_acc && paddr == irf_pkg::ADDR_REQ_TWO
        |-> {prdata[5:4], prdata[1]} == 3'h7) else $error("fixed bits of second flag register not read as 1");
    a_direct_set: assert property (events.direct_transfer_done && events.direct_transfer_enable
        |=> request_flags_two[7]) else $error("direct transfer flag not set");
    a_converter_done: assert property ($fell(events.converter_start_busy_bit) |=> request_flags_two[6])
        else $error("converter flag not set when busy fell");
    a_tf_high_set: assert property ((events.timer_f_mode_16 ? events.timer_f_full_match
        : events.timer_f_high_match) |=> request_flags_two[3]) else $error("timer F high flag not set");
    a_tf_low_cause: assert property ($rose(request_flags_two[2])
        |-> $past(events.timer_f_low_match && !events.timer_f_mode_16)) else $error("timer F low flag without cause");
    a_counter_set: assert property ((events.event_counter_upper_ovf || (!events.event_counter_mode_16
        && events.event_counter_lower_ovf)) |=> request_flags_two[0]) else $error("counter flag not set");

    // Main scenarios reached
    c_timer_wrap: cover property (events.timer_a_count == 8'h00 && $past(events.timer_a_count) == 8'hff);
    c_set_and_clear: cover property (wr_two && !pwdata[3] && events.timer_f_high_match);
    c_unmapped: cover property (psel && penable && pslverr);
endmodule

bind irf_flags irf_flags_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .events(events), .requests(requests), .request_flags_one(request_flags_one),
    .request_flags_two(request_flags_two), .wakeup_request_flags(wakeup_request_flags));

`default_nettype wire

// *** tb/irf_partner.sv ***
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Pins and peripheral strobes
// ----------------------------------------
module irf_partner (
    input wire logic pclk,
    output var irf_pkg::irf_pins_t pins,
    output var irf_pkg::irf_events_t events
);
    // Quiet pins and idle peripherals from time zero
    initial begin
        pins = '0;
        events = '0;
    end

    // One-cycle strobe; count ff then 00 wraps timer A, busy 1 then 0 ends conversion
    task pulse(input logic [18:0] m);
        @(posedge pclk);
        events <= events | m;
        @(posedge pclk);
        events <= events & ~m;
    endtask

    // Pins change only after an edge; the block synchronises them itself
    task drive(input logic [10:0] v);
        @(posedge pclk);
        pins <= v;
    endtask
endmodule

`default_nettype wire

// *** tb/irf_flags_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module irf_flags_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, rf_one, rf_two, rf_wake;
    logic [31:0] pwdata, prdata, rd;
    irf_pkg::irf_pins_t pins;
    irf_pkg::irf_events_t events;
    irf_pkg::irf_requests_t requests;
    int n_mismatch = 0;
    int samples_checked = 0;
    // Strobe masks on the packed event struct, with the flag bit each should set
    localparam logic [18:0] EV [11] = '{19'h00040, 19'h00020, 19'h000a0, 19'h00090, 19'h000c0, 19'h00002,
        19'h0000a, 19'h0000c, 19'h00600, 19'h00400, 19'h00100};
    localparam logic [7:0] EX [11] = '{8'h08, 8'h04, 8'h00, 8'h08, 8'h00, 8'h01, 8'h00, 8'h01, 8'h80, 8'h00, 8'h40};

    irf_flags uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
        .events(events), .requests(requests), .request_flags_one(rf_one), .request_flags_two(rf_two),
        .wakeup_request_flags(rf_wake));
    irf_partner far_end (.pclk(pclk), .pins(pins), .events(events));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset_regs();
        apb(1'b0, irf_pkg::ADDR_REQ_ONE, 32'h0); check(rd, 32'h78);
        apb(1'b1, irf_pkg::ADDR_REQ_ONE, 32'hff); apb(1'b0, irf_pkg::ADDR_REQ_ONE, 32'h0); check(rd, 32'h78);
        apb(1'b0, irf_pkg::ADDR_REQ_TWO, 32'h0); check(rd, 32'h32);
        apb(1'b0, irf_pkg::ADDR_WAKE_REQ, 32'h0); check(rd, 32'h0);
        apb(1'b0, irf_pkg::ADDR_WAKE_EDGE, 32'h0); check(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0); check({rd[30:0], err}, 32'h1);
        $display("test reset_regs done");
    endtask

    // Acceptance strobe between event and read must not disturb any flag
    task t_peripheral_flags();
        for (int i = 0; i < 11; i++) begin
            far_end.pulse(EV[i]);
            far_end.pulse(19'h00001);
            apb(1'b0, irf_pkg::ADDR_REQ_TWO, 32'h0); check(rd, {24'h0, EX[i] | 8'h32});
            apb(1'b1, irf_pkg::ADDR_REQ_TWO, 32'hff);
            apb(1'b0, irf_pkg::ADDR_REQ_TWO, 32'h0); check(rd, {24'h0, EX[i] | 8'h32});
            apb(1'b1, irf_pkg::ADDR_REQ_TWO, 32'h0);
            apb(1'b0, irf_pkg::ADDR_REQ_TWO, 32'h0); check(rd, 32'h32);
        end
        far_end.pulse(19'h7f800);
        apb(1'b0, irf_pkg::ADDR_REQ_ONE, 32'h0); check(rd, 32'hf8);
        $display("test peripheral_flags done");
    endtask

    task t_enable_gate();
        @(negedge pclk); check({31'h0, requests.timer_a}, 32'h0);
        apb(1'b1, irf_pkg::ADDR_ENABLE_ONE, 32'h80);
        apb(1'b0, irf_pkg::ADDR_ENABLE_ONE, 32'h0); check(rd, 32'hd8);
        @(negedge pclk); check({31'h0, requests.timer_a}, 32'h1);
        apb(1'b1, irf_pkg::ADDR_REQ_ONE, 32'h0);
        repeat (2) @(negedge pclk); check({31'h0, requests.timer_a}, 32'h0);
        apb(1'b1, irf_pkg::ADDR_ENABLE_ONE, 32'h0);
        // Second enable register gates the timer F high request one edge after its flag
        apb(1'b1, irf_pkg::ADDR_ENABLE_TWO, 32'hff);
        apb(1'b0, irf_pkg::ADDR_ENABLE_TWO, 32'h0); check(rd, 32'hff);
        far_end.pulse(19'h00040);
        repeat (2) @(negedge pclk); check({31'h0, requests.timer_f_high}, 32'h1);
        apb(1'b1, irf_pkg::ADDR_REQ_TWO, 32'h0);
        apb(1'b1, irf_pkg::ADDR_ENABLE_TWO, 32'h0);
        $display("test enable_gate done");
    endtask

    // Strobe lands on the very edge that the write of 0 takes effect
    task t_set_beats_clear();
        fork
            apb(1'b1, irf_pkg::ADDR_REQ_TWO, 32'h0);
            begin
                @(posedge pclk);
                far_end.pulse(19'h00040);
            end
        join
        apb(1'b0, irf_pkg::ADDR_REQ_TWO, 32'h0); check(rd, 32'h3a);
        apb(1'b1, irf_pkg::ADDR_REQ_TWO, 32'h0);
        $display("test set_beats_clear done");
    endtask

    // Only wakeup pins 3..0 in use; odd pins rise-sensitive, even pins fall
    task t_pin_edges();
        apb(1'b1, irf_pkg::ADDR_PIN_CONFIG, 32'h79);
        apb(1'b1, irf_pkg::ADDR_WAKE_MODE, 32'h0f);
        apb(1'b1, irf_pkg::ADDR_WAKE_EDGE, 32'haa);
        far_end.drive(11'h7ff);
        repeat (6) @(posedge pclk);
        apb(1'b0, irf_pkg::ADDR_WAKE_REQ, 32'h0); check(rd, 32'h0a);
        apb(1'b0, irf_pkg::ADDR_REQ_ONE, 32'h0); check(rd, 32'h7d);
        apb(1'b1, irf_pkg::ADDR_WAKE_REQ, 32'h0);
        apb(1'b1, irf_pkg::ADDR_REQ_ONE, 32'h0);
        repeat (6) @(posedge pclk);
        apb(1'b0, irf_pkg::ADDR_WAKE_REQ, 32'h0); check(rd, 32'h0);
        far_end.drive(11'h000);
        repeat (6) @(posedge pclk);
        apb(1'b0, irf_pkg::ADDR_WAKE_REQ, 32'h0); check(rd, 32'h05);
        apb(1'b0, irf_pkg::ADDR_REQ_ONE, 32'h0); check(rd, 32'h7e);
        apb(1'b0, irf_pkg::ADDR_WAKE_EDGE, 32'h0); check(rd, 32'haa);
        $display("test pin_edges done");
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_regs();
        t_peripheral_flags();
        t_enable_gate();
        t_set_beats_clear();
        t_pin_edges();
        complete_run();
    end

    initial begin
        repeat (50000) @(posedge pclk);
        n_mismatch++;
        complete_run();
    end
endmodule

`default_nettype wire
